// >>> verilog/mcc_pkg.sv
// constants and types for the configure command interpreter
package mcc_pkg;

   // ***********************************
   // command block layout
   // ***********************************
   localparam int          MCC_EL_BIT        = 31;
   localparam int          MCC_SUSPEND_BIT   = 30;
   localparam int          MCC_INT_BIT       = 29;
   localparam int          MCC_CMD_LSB       = 16;
   localparam int          MCC_DONE_BIT      = 15;
   localparam int          MCC_OK_BIT        = 13;
   localparam logic [2:0]  MCC_CMD_CONFIGURE = 3'h2;
   localparam logic [31:0] MCC_LINK_OFS      = 32'h0000_0004;
   localparam logic [31:0] MCC_PARAM_OFS     = 32'h0000_0008;

   // ***********************************
   // parameter list sizes
   // ***********************************
   localparam int          MCC_PARAM_MAX     = 22;
   localparam int          MCC_CU_BYTES      = 8;
   localparam int          MCC_PHY_BYTE      = 8;
   localparam int          MCC_RXDMA_BYTE    = 4;
   localparam logic [4:0]  MCC_CNT_MAX       = 5'h16;
   localparam logic [5:0]  MCC_CNT_MIN       = 6'h08;
   localparam logic [4:0]  MCC_FWD_FIRST     = 5'h08;
   localparam logic [4:0]  MCC_FWD_LAST      = 5'h15;

   // default bytes, byte 21 first, byte 0 last
   localparam logic [MCC_PARAM_MAX*8-1:0] MCC_CFG_DEFAULT = {
      8'h05, 8'h3F, 8'h00, 8'hF0, 8'h40, 8'h00, 8'h48, 8'hF2, 8'h00, 8'h00, 8'h00,
      8'h06, 8'h00, 8'h00, 8'h00, 8'h32, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h16};

   // ***********************************
   // register map
   // ***********************************
   localparam logic [7:0]  MCC_REG_CTRL      = 8'h00;
   localparam logic [7:0]  MCC_REG_BASE      = 8'h04;
   localparam logic [7:0]  MCC_REG_OFFSET    = 8'h08;
   localparam logic [7:0]  MCC_REG_STATUS    = 8'h0C;
   localparam logic [7:0]  MCC_REG_IRQ_STAT  = 8'h10;
   localparam logic [7:0]  MCC_REG_IRQ_MASK  = 8'h14;
   localparam logic [7:0]  MCC_REG_CU_LO     = 8'h18;
   localparam logic [7:0]  MCC_REG_CU_HI     = 8'h1C;
   localparam int          MCC_IRQ_N         = 3;
   localparam int          MCC_IRQ_NOT_ACT   = 0;
   localparam int          MCC_IRQ_DONE      = 1;
   localparam int          MCC_IRQ_ERR       = 2;

   typedef enum logic [2:0] {
      MCC_S_IDLE, MCC_S_CMD, MCC_S_LINK, MCC_S_PARAM,
      MCC_S_FWD, MCC_S_STAT, MCC_S_SUSP
   } mcc_state_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mcc_mem_req_t;

endpackage : mcc_pkg

// >>> verilog/mcc_param_store.sv
// configuration byte store with per-byte defaults
`timescale 1ns/1ps
module mcc_param_store #(
   parameter int NBYTES = mcc_pkg::MCC_PARAM_MAX
) (
   input  wire logic                clk_in,
   input  wire logic                rst_in,
   input  wire logic                load_def_in,
   input  wire logic                wr_in,
   input  wire logic [2:0]          word_idx_in,
   input  wire logic [3:0]          byte_en_in,
   input  wire logic [31:0]         wdata_in,
   output logic      [NBYTES*8-1:0] bytes_out
);

   initial begin
      if (NBYTES != mcc_pkg::MCC_PARAM_MAX) $error("store size must match parameter list");
   end

   // ***********************************
   // one register per byte
   // ***********************************
   genvar i;
   generate
      for (i = 0; i < NBYTES; i++) begin : g_byte
         localparam logic [2:0] WORD = 3'(i / 4);
         localparam int         LANE = i % 4;
         wire  logic            hit  = wr_in & (word_idx_in == WORD) & byte_en_in[LANE];
         wire  logic [7:0]      wb   = wdata_in[LANE*8 +: 8];
         logic [7:0]            byte_reg;
         always_ff @(posedge clk_in) begin
            if (rst_in || load_def_in) begin
               byte_reg <= mcc_pkg::MCC_CFG_DEFAULT[i*8 +: 8];
            end else if (hit) begin
               if (i == mcc_pkg::MCC_RXDMA_BYTE) begin
                  byte_reg <= {1'b0, wb[6:0]}; // [R10]
               end else begin
                  byte_reg <= wb;
               end
            end
         end
         assign bytes_out[i*8 +: 8] = byte_reg;
      end
   endgenerate

endmodule : mcc_param_store

// >>> verilog/mcc_irq_ctrl.sv
// sticky interrupt status, mask and level output
`timescale 1ns/1ps
module mcc_irq_ctrl #(
   parameter int N = mcc_pkg::MCC_IRQ_N
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [N-1:0] event_in,
   input  wire logic         clr_we_in,
   input  wire logic [N-1:0] clr_in,
   input  wire logic         mask_we_in,
   input  wire logic [N-1:0] mask_in,
   output logic      [N-1:0] status_out,
   output logic      [N-1:0] mask_out,
   output logic              irq_out
);

   initial begin
      if (N < 1 || N > 32) $error("interrupt count out of range");
   end

   logic [N-1:0] status_reg;
   logic [N-1:0] mask_reg;
   logic         irq_reg;

   // ***********************************
   // set wins over write-one-to-clear
   // ***********************************
   wire logic [N-1:0] status_next = event_in | (status_reg & ~(clr_we_in ? clr_in : '0));

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         status_reg <= '0;
         mask_reg   <= '0;
         irq_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         mask_reg   <= mask_we_in ? mask_in : mask_reg;
         irq_reg    <= |(status_next & (mask_we_in ? mask_in : mask_reg));
      end
   end

   assign status_out = status_reg;
   assign mask_out   = mask_reg;
   assign irq_out    = irq_reg;

endmodule : mcc_irq_ctrl

// >>> verilog/mcc_configure_top.sv
// configure command interpreter: wishbone slave, block fetch, forwarding
//
// Operation
// R1: command code 010b selects configure
// R2: parameter list holds at most 22 bytes
// R3: command unit keeps first eight bytes
// R4: bytes past eight forwarded to CSMA/CD
// R5: host supplies byte count of eight or more
// R6: uncovered parameters take default values
// R7: no traffic until PHY bit written
// R8: early variant: PHY bit any value, written
// R9: host writes byte 3 as zero
// R10: byte 4 top bit held zero
// R11: host clears completion; device sets it
// R12: OK set on success, clear on error
// R13: end-of-list: go idle, raise interrupt
// R14: suspend flag: go suspended after block
// R15: four bytes per longword, from offset 8
// R16: byte count from byte 0 low bits
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module mcc_configure_top (
   input  wire logic                  SYS_CLK_IN,
   input  wire logic                  RESET_IN,
   input  wire logic                  WB_CYC_IN,
   input  wire logic                  WB_STB_IN,
   input  wire logic                  WB_WE_IN,
   input  wire logic [7:0]            WB_ADR_IN,
   input  wire logic [3:0]            WB_SEL_IN,
   input  wire logic [31:0]           WB_DAT_IN,
   output logic      [31:0]           WB_DAT_OUT,
   output logic                       WB_ACK_OUT,
   output mcc_pkg::mcc_mem_req_t      MEM_OUT,
   input  wire logic                  MEM_ACK_IN,
   input  wire logic [31:0]           MEM_RDATA_IN,
   output logic                       FWD_VALID_OUT,
   output logic      [7:0]            FWD_DATA_OUT,
   output logic      [4:0]            FWD_INDEX_OUT,
   input  wire logic                  FWD_READY_IN,
   output logic      [63:0]           CU_PARAMS_OUT,
   output logic                       TXRX_ENABLE_OUT,
   output logic                       IRQ_OUT
);

   // ***********************************
   // state
   // ***********************************
   mcc_pkg::mcc_state_t   state_reg;
   mcc_pkg::mcc_mem_req_t mem_reg;
   logic [31:0]           blk_reg;
   logic [31:0]           cmd_reg;
   logic [31:0]           link_reg;
   logic [2:0]            widx_reg;
   logic [4:0]            cnt_reg;
   logic                  err_reg;
   logic [4:0]            fidx_reg;
   logic                  fvalid_reg;
   logic [7:0]            fdata_reg;
   logic                  phy_set_reg;
   logic [31:0]           base_reg;
   logic [31:0]           offset_reg;
   logic                  ack_reg;
   logic [31:0]           dat_reg;
   logic [175:0]          cfg_bytes;
   logic [2:0]            irq_stat;
   logic [2:0]            irq_mask;
   logic                  irq_line;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int k = 0; k < 4; k++) begin
         if (s[k]) r[k*8 +: 8] = n[k*8 +: 8];
      end
      return r;
   endfunction : merge

   // ***********************************
   // bus decode
   // ***********************************
   wire logic wb_req    = WB_CYC_IN & WB_STB_IN & ~ack_reg;
   wire logic wb_wr     = wb_req & WB_WE_IN;
   wire logic sel_ctrl  = WB_ADR_IN == mcc_pkg::MCC_REG_CTRL;
   wire logic sel_base  = WB_ADR_IN == mcc_pkg::MCC_REG_BASE;
   wire logic sel_ofs   = WB_ADR_IN == mcc_pkg::MCC_REG_OFFSET;
   wire logic sel_stat  = WB_ADR_IN == mcc_pkg::MCC_REG_STATUS;
   wire logic sel_istat = WB_ADR_IN == mcc_pkg::MCC_REG_IRQ_STAT;
   wire logic sel_imask = WB_ADR_IN == mcc_pkg::MCC_REG_IRQ_MASK;
   wire logic sel_cu_lo = WB_ADR_IN == mcc_pkg::MCC_REG_CU_LO;
   wire logic sel_cu_hi = WB_ADR_IN == mcc_pkg::MCC_REG_CU_HI;
   wire logic ctrl_wr   = wb_wr & sel_ctrl & WB_SEL_IN[0];
   wire logic start_cmd = ctrl_wr & WB_DAT_IN[0];
   wire logic resume    = ctrl_wr & WB_DAT_IN[1];
   wire logic [31:0] rd_mux =
      sel_base  ? base_reg :
      sel_ofs   ? offset_reg :
      sel_stat  ? {27'h000_0000, err_reg, phy_set_reg, state_reg} :
      sel_istat ? {29'h0000_0000, irq_stat} :
      sel_imask ? {29'h0000_0000, irq_mask} :
      sel_cu_lo ? cfg_bytes[31:0] :
      sel_cu_hi ? cfg_bytes[63:32] : 32'h0000_0000;

   // ***********************************
   // block decode
   // ***********************************
   wire logic        mem_ack   = mem_reg.req & MEM_ACK_IN;
   wire logic        in_cmd    = state_reg == mcc_pkg::MCC_S_CMD;
   wire logic        in_link   = state_reg == mcc_pkg::MCC_S_LINK;
   wire logic        in_param  = state_reg == mcc_pkg::MCC_S_PARAM;
   wire logic        in_fwd    = state_reg == mcc_pkg::MCC_S_FWD;
   wire logic        in_stat   = state_reg == mcc_pkg::MCC_S_STAT;
   wire logic [2:0]  cmd_code  = cmd_reg[mcc_pkg::MCC_CMD_LSB +: 3];
   wire logic        is_cfg    = cmd_code == mcc_pkg::MCC_CMD_CONFIGURE; // [R1]
   wire logic        load_def  = in_link & mem_ack & is_cfg; // [R6]
   wire logic [5:0]  raw_cnt   = MEM_RDATA_IN[5:0]; // [R16]
   wire logic        cnt_bad   = (raw_cnt < mcc_pkg::MCC_CNT_MIN) |
                                 (raw_cnt > {1'b0, mcc_pkg::MCC_CNT_MAX});
   wire logic [4:0]  cnt_in    = (raw_cnt > {1'b0, mcc_pkg::MCC_CNT_MAX}) ?
                                 mcc_pkg::MCC_CNT_MAX : raw_cnt[4:0]; // [R2]
   wire logic [4:0]  cnt_now   = (widx_reg == 3'h0) ? cnt_in : cnt_reg;
   wire logic [4:0]  wbase     = {widx_reg, 2'b00};
   wire logic [4:0]  wnext     = wbase + 5'h04;
   wire logic        last_word = wnext >= cnt_now;
   wire logic        st_wr     = in_param & mem_ack;
   wire logic [3:0]  byte_en;
   wire logic [31:0] blk_stat  = {cmd_reg[31:16], 1'b1, cmd_reg[14], ~err_reg,
                                  cmd_reg[12:0]}; // [R11] [R12]
   wire logic        fin       = in_stat & mem_ack;
   wire logic        fin_el    = fin & cmd_reg[mcc_pkg::MCC_EL_BIT];
   wire logic        fin_susp  = fin & ~fin_el & cmd_reg[mcc_pkg::MCC_SUSPEND_BIT];
   wire logic [2:0]  irq_ev    = {fin & err_reg,
                                  fin & cmd_reg[mcc_pkg::MCC_INT_BIT],
                                  fin_el | fin_susp}; // [R13]
   wire logic        fwd_take  = fvalid_reg & FWD_READY_IN;

   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign byte_en[b] = (wbase + 5'(b)) < cnt_now; // [R15]
      end
   endgenerate

   // ***********************************
   // wishbone slave registers
   // ***********************************
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         ack_reg    <= 1'b0;
         dat_reg    <= 32'h0000_0000;
         base_reg   <= 32'h0000_0000;
         offset_reg <= 32'h0000_0000;
      end else begin
         ack_reg    <= wb_req;
         dat_reg    <= wb_req ? rd_mux : dat_reg;
         base_reg   <= (wb_wr & sel_base) ? merge(base_reg, WB_DAT_IN, WB_SEL_IN) : base_reg;
         offset_reg <= (wb_wr & sel_ofs) ? merge(offset_reg, WB_DAT_IN, WB_SEL_IN) : offset_reg;
      end
   end

   // ***********************************
   // command block sequencer
   // ***********************************
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         state_reg <= mcc_pkg::MCC_S_IDLE;
         mem_reg   <= '0;
         blk_reg   <= 32'h0000_0000;
         cmd_reg   <= 32'h0000_0000;
         link_reg  <= 32'h0000_0000;
         widx_reg  <= 3'h0;
         cnt_reg   <= 5'h00;
         err_reg   <= 1'b0;
      end else begin
         if (mem_ack) mem_reg.req <= 1'b0;
         unique case (state_reg)
            mcc_pkg::MCC_S_IDLE, mcc_pkg::MCC_S_SUSP: begin
               if ((state_reg == mcc_pkg::MCC_S_IDLE) ? start_cmd : resume) begin
                  blk_reg   <= base_reg + ((state_reg == mcc_pkg::MCC_S_IDLE) ?
                                           offset_reg : link_reg);
                  mem_reg   <= '{req: 1'b1, we: 1'b0, wdata: 32'h0000_0000,
                                 addr: base_reg + ((state_reg == mcc_pkg::MCC_S_IDLE) ?
                                                   offset_reg : link_reg)};
                  state_reg <= mcc_pkg::MCC_S_CMD;
               end
            end
            mcc_pkg::MCC_S_CMD: begin
               if (mem_ack) begin
                  cmd_reg     <= MEM_RDATA_IN;
                  err_reg     <= 1'b0;
                  mem_reg     <= '{req: 1'b1, we: 1'b0, wdata: 32'h0000_0000,
                                   addr: blk_reg + mcc_pkg::MCC_LINK_OFS};
                  state_reg   <= mcc_pkg::MCC_S_LINK;
               end
            end
            mcc_pkg::MCC_S_LINK: begin
               if (mem_ack) begin
                  link_reg <= MEM_RDATA_IN;
                  widx_reg <= 3'h0;
                  if (is_cfg) begin // [R1]
                     mem_reg   <= '{req: 1'b1, we: 1'b0, wdata: 32'h0000_0000,
                                    addr: blk_reg + mcc_pkg::MCC_PARAM_OFS}; // [R15]
                     state_reg <= mcc_pkg::MCC_S_PARAM;
                  end else begin
                     err_reg   <= 1'b1;
                     mem_reg   <= '{req: 1'b1, we: 1'b1, addr: blk_reg,
                                    wdata: {cmd_reg[31:16], 1'b1, cmd_reg[14], 1'b0,
                                            cmd_reg[12:0]}}; // [R12]
                     state_reg <= mcc_pkg::MCC_S_STAT;
                  end
               end
            end
            mcc_pkg::MCC_S_PARAM: begin
               if (mem_ack) begin
                  if (widx_reg == 3'h0) begin
                     cnt_reg <= cnt_in; // [R16]
                     err_reg <= cnt_bad;
                  end
                  widx_reg <= widx_reg + 3'h1;
                  if (last_word) begin
                     state_reg <= mcc_pkg::MCC_S_FWD; // [R4]
                  end else begin
                     mem_reg <= '{req: 1'b1, we: 1'b0, wdata: 32'h0000_0000,
                                  addr: blk_reg + mcc_pkg::MCC_PARAM_OFS +
                                        {27'h000_0000, wnext}}; // [R15]
                  end
               end
            end
            mcc_pkg::MCC_S_FWD: begin
               if (fwd_take && fidx_reg == mcc_pkg::MCC_FWD_LAST) begin
                  mem_reg   <= '{req: 1'b1, we: 1'b1, addr: blk_reg, wdata: blk_stat};
                  state_reg <= mcc_pkg::MCC_S_STAT;
               end
            end
            mcc_pkg::MCC_S_STAT: begin
               if (mem_ack) begin
                  if (fin_el) begin
                     state_reg <= mcc_pkg::MCC_S_IDLE; // [R13]
                  end else if (fin_susp) begin
                     state_reg <= mcc_pkg::MCC_S_SUSP; // [R14]
                  end else begin
                     blk_reg   <= base_reg + link_reg;
                     mem_reg   <= '{req: 1'b1, we: 1'b0, wdata: 32'h0000_0000,
                                    addr: base_reg + link_reg};
                     state_reg <= mcc_pkg::MCC_S_CMD;
                  end
               end
            end
            default: state_reg <= mcc_pkg::MCC_S_IDLE;
         endcase
      end
   end

   // ***********************************
   // forwarding of bytes 8..21
   // ***********************************
   always_ff @(posedge SYS_CLK_IN) begin
      if (RESET_IN) begin
         fidx_reg    <= mcc_pkg::MCC_FWD_FIRST;
         fvalid_reg  <= 1'b0;
         fdata_reg   <= 8'h00;
         phy_set_reg <= 1'b0;
      end else begin
         if (!in_fwd) begin
            fidx_reg   <= mcc_pkg::MCC_FWD_FIRST; // [R3]
            fvalid_reg <= 1'b0;
         end else if (!fvalid_reg) begin
            fdata_reg  <= cfg_bytes[{fidx_reg, 3'b000} +: 8]; // [R4]
            fvalid_reg <= 1'b1;
         end else if (fwd_take) begin
            fvalid_reg <= 1'b0;
            fidx_reg   <= fidx_reg + 5'h01;
         end
         if (st_wr && widx_reg == 3'(mcc_pkg::MCC_PHY_BYTE / 4) && byte_en[0]) begin
            phy_set_reg <= 1'b1; // [R7]
         end
      end
   end

   // ***********************************
   // submodules
   // ***********************************
   mcc_param_store #(.NBYTES(mcc_pkg::MCC_PARAM_MAX)) u_store (
      .clk_in      (SYS_CLK_IN),
      .rst_in      (RESET_IN),
      .load_def_in (load_def),
      .wr_in       (st_wr),
      .word_idx_in (widx_reg),
      .byte_en_in  (byte_en),
      .wdata_in    (MEM_RDATA_IN),
      .bytes_out   (cfg_bytes)
   );

   mcc_irq_ctrl #(.N(mcc_pkg::MCC_IRQ_N)) u_irq (
      .clk_in     (SYS_CLK_IN),
      .rst_in     (RESET_IN),
      .event_in   (irq_ev),
      .clr_we_in  (wb_wr & sel_istat & WB_SEL_IN[0]),
      .clr_in     (WB_DAT_IN[2:0]),
      .mask_we_in (wb_wr & sel_imask & WB_SEL_IN[0]),
      .mask_in    (WB_DAT_IN[2:0]),
      .status_out (irq_stat),
      .mask_out   (irq_mask),
      .irq_out    (irq_line)
   );

   assign WB_DAT_OUT      = dat_reg;
   assign WB_ACK_OUT      = ack_reg;
   assign MEM_OUT         = mem_reg;
   assign FWD_VALID_OUT   = fvalid_reg;
   assign FWD_DATA_OUT    = fdata_reg;
   assign FWD_INDEX_OUT   = fidx_reg;
   assign CU_PARAMS_OUT   = cfg_bytes[63:0]; // [R3]
   assign TXRX_ENABLE_OUT = phy_set_reg;
   assign IRQ_OUT         = irq_line;

   // ***********************************
   // assertions
   // ***********************************
   property p_r1_other_cmd;
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (in_link && mem_ack && !is_cfg) |=> (in_stat && mem_reg.we && !mem_reg.wdata[13]);
   endproperty
   a_r1_other_cmd: assert property (p_r1_other_cmd) else $error("non-configure not refused"); // [R1]

   property p_r2_cnt_cap;
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      in_fwd |-> (cnt_reg <= mcc_pkg::MCC_CNT_MAX && cnt_reg != 5'h00);
   endproperty
   a_r2_cnt_cap: assert property (p_r2_cnt_cap) else $error("byte count above limit"); // [R2]

   property p_r3_fwd_start;
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (in_param && mem_ack && last_word) |=> ##1 (fvalid_reg && fidx_reg == 5'h08);
   endproperty
   a_r3_fwd_start: assert property (p_r3_fwd_start) else $error("forward not at byte 8"); // [R3]

   property p_r4_hold;
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (fvalid_reg && !FWD_READY_IN) |=> (fvalid_reg && $stable(fdata_reg) && $stable(fidx_reg));
   endproperty
   a_r4_hold: assert property (p_r4_hold) else $error("forward byte dropped"); // [R4]

   property p_r7_enable;
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      $rose(phy_set_reg) |-> $past(st_wr) && $past(widx_reg) == 3'h2;
   endproperty
   a_r7_enable: assert property (p_r7_enable) else $error("traffic enabled early"); // [R7]

   property p_r10_rxdma;
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      $past(st_wr) |-> !cfg_bytes[39];
   endproperty
   a_r10_rxdma: assert property (p_r10_rxdma) else $error("byte 4 top bit set"); // [R10]

   property p_r11_done;
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (in_stat && mem_reg.req) |-> (mem_reg.we && mem_reg.wdata[15] && mem_reg.addr == blk_reg);
   endproperty
   a_r11_done: assert property (p_r11_done) else $error("completion flag not written"); // [R11]

   property p_r12_ok;
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      (in_stat && mem_reg.req) |-> (mem_reg.wdata[13] == !err_reg);
   endproperty
   a_r12_ok: assert property (p_r12_ok) else $error("success flag wrong"); // [R12]

   property p_r13_idle;
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      fin_el |=> (state_reg == mcc_pkg::MCC_S_IDLE && irq_stat[0]);
   endproperty
   a_r13_idle: assert property (p_r13_idle) else $error("end of list not idle"); // [R13]

   property p_r14_susp;
      @(posedge SYS_CLK_IN) disable iff (RESET_IN)
      fin_susp |=> (state_reg == mcc_pkg::MCC_S_SUSP) ##1 (irq_stat[0]);
   endproperty
   a_r14_susp: assert property (p_r14_susp) else $error("suspend not taken"); // [R14]

endmodule : mcc_configure_top

// >>> tb/mcc_mem_model.sv
// host memory model serving command blocks
`timescale 1ns/1ps
module mcc_mem_model (
   input  wire logic             clk_in,
   input  wire logic             slow_in,
   input  mcc_pkg::mcc_mem_req_t req_in,
   output logic                  ack_out = 1'b0,
   output logic [31:0]           rdata_out = 32'h0000_0000
);
   logic [31:0] mem [64];  // blocks built by driver
   logic        hold_reg = 1'b0;
   always @(posedge clk_in) begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;  // no stale data outside ack
      hold_reg <= slow_in & ~hold_reg;
      if (req_in.req && !ack_out && (!slow_in || hold_reg)) begin
         ack_out <= 1'b1;
         rdata_out <= mem[req_in.addr[7:2]];
         if (req_in.we) mem[req_in.addr[7:2]] <= req_in.wdata;
      end
   end
endmodule : mcc_mem_model

// >>> tb/mac_configure_command_bench.sv
// self-checking bench for the configure command interpreter
`timescale 1ns/1ps
module mac_configure_command_bench;
   logic clk = 0, rst = 1, cyc = 0, we = 0, rdy = 0, slow = 0, ack, mack, fv, txe, irq;
   logic [7:0] adr = 0, fd, fwd [22];
   logic [31:0] wd = 0, rd, rdat, mrd;
   logic [4:0] fi;
   logic [63:0] cup;
   mcc_pkg::mcc_mem_req_t mreq;
   int failures = 0, check_count = 0;
   always #5 clk = ~clk;
   mcc_configure_top dut_u (.SYS_CLK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(cyc),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wd), .WB_DAT_OUT(rdat),
      .WB_ACK_OUT(ack), .MEM_OUT(mreq), .MEM_ACK_IN(mack), .MEM_RDATA_IN(mrd),
      .FWD_VALID_OUT(fv), .FWD_DATA_OUT(fd), .FWD_INDEX_OUT(fi), .FWD_READY_IN(rdy),
      .CU_PARAMS_OUT(cup), .TXRX_ENABLE_OUT(txe), .IRQ_OUT(irq));
   mcc_mem_model mem_u (.clk_in(clk), .slow_in(slow), .req_in(mreq), .ack_out(mack),
      .rdata_out(mrd));
   always @(posedge clk) begin
      rdy <= ~rdy;  // far side stalls every other cycle
      if (fv && rdy) fwd[fi] <= fd;
   end
   task automatic check(input string what, input logic [63:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1;
      we  <= w;
      adr <= a;
      wd  <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 0;
   endtask : wb
   task automatic irq_is(input logic v);
      repeat (2) @(posedge clk);
      check("irq line", irq, v);
   endtask : irq_is
   task automatic cfg(input logic [15:0] cmd, input int cnt, input logic ok, logic [2:0] st);
      logic [7:0] b [24];
      logic [7:0] e;
      for (int i = 0; i < 24; i++) b[i] = (i < cnt) ? 8'h80 + 8'(i) : 8'h00;
      b[0] = 8'(cnt);
      b[3] = 8'h00;
      mem_u.mem[4] = {cmd, 16'h0000};
      mem_u.mem[5] = 32'h0000_0030;  // link to the block at 0x30
      for (int w = 0; w < 6; w++) mem_u.mem[6+w] = {b[4*w+3], b[4*w+2], b[4*w+1], b[4*w]};
      wb(1, 8'h00, 32'h0000_0001);
      while (irq !== 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
      check("status word", mem_u.mem[4], {cmd, 2'b10, ok, 13'h0000});
      for (int i = 0; i < 22; i++) begin
         e = (i < cnt) ? b[i] : mcc_pkg::MCC_CFG_DEFAULT[i*8+:8];
         if (i == 4) e[7] = 1'b0;
         if (i < 8) check("cu byte", cup[i*8+:8], e);
         else check("fwd byte", fwd[i], e);
      end
      wb(0, 8'h0C, 32'h0000_0000);
      check("unit state", rd[2:0], st);
      wb(0, 8'h10, 32'h0000_0000);
      check("irq status", rd[2:0], {~ok, 2'b11});
      wb(1, 8'h14, 32'h0000_0000);
      irq_is(0);
      wb(1, 8'h14, 32'h0000_0007);
      irq_is(1);
      wb(1, 8'h10, 32'h0000_0007);
      irq_is(0);
   endtask : cfg
   task automatic resume_other;
      mem_u.mem[12] = 32'h8001_0000;
      wb(1, 8'h00, 32'h0000_0002);
      while (irq !== 1'b1) @(posedge clk);
      repeat (2) @(posedge clk);
      check("other status", mem_u.mem[12], 32'h8001_8000);
      wb(0, 8'h0C, 32'h0000_0000);
      check("other state", rd[2:0], 3'h0);
      wb(0, 8'h10, 32'h0000_0000);
      check("other irq", rd[2:0], 3'h5);
   endtask : resume_other
   task automatic stop_test;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   initial begin
      #400000;
      failures++;
      stop_test;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 0;
      check("phy off", txe, 0);
      wb(0, 8'hFC, 32'h0000_0000);
      check("unmapped", rd, 0);
      wb(1, 8'h04, 32'h0000_0000);
      wb(1, 8'h08, 32'h0000_0010);
      wb(1, 8'h14, 32'h0000_0007);
      cfg(16'hA002, 12, 1, 3'h0);
      check("phy on", txe, 1);
      slow <= 1;
      cfg(16'hA002, 5, 0, 3'h0);
      cfg(16'h6002, 22, 1, 3'h6);
      resume_other;
      stop_test;
   end
endmodule : mac_configure_command_bench
